// ===== hdl/cal_regs.v
/*
 Calibration and correction register set of a bridge converter's
 post-processor: configuration, coarse offset trim, gain, ratiometric and
 non-ratiometric offsets, with a simple calibration sequencer.
 Assumes a single-cycle register port master on clk and an external
 calibration engine that supplies result words.
*/
// The register offsets and strobed register access were left to the implementer.
// Notes on behaviour
// - Five calibration stores held here
// - Non-ratiometric offsets: 24-bit two's complement
// - Ratiometric offset: 24-bit two's complement
// - Ratiometric count weighs 2^-23 of reference
// - Gain unsigned, 2^-23 up to two
// - Gain 0.5..2.0 accepted, above 1.2 coarse
// - Ratiometric cal sets trim, then fine word
// - Gain and offset words readable and writable back
// - PGA 1,2,4,8 over fixed gain 25
// - Mode pin low selects five/four-wire port
// - Trim register 24 bits, sign 23, magnitude 22..20
// - Sign 0 adds, 1 subtracts offset
// - Magnitude steps of 25 percent
// - Bits 19..0 read back configuration
// - Writes leave mirrored bits unchanged
// - Cal control 7..4, cal enable at 10
// - Gain resets to unity, MSB only
`timescale 1ns/1ns
`include "cal_regs_consts.vh"

module cal_regs
(
   input wire clk,
   input wire rst_n,
   input wire [`ADDR_W-1:0] addr,
   input wire [`WORD_W-1:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [`WORD_W-1:0] rdata,
   input wire interface_mode_pin,
   input wire cal_done,
   input wire [`TRIM_W-1:0] cal_trim,
   input wire [`WORD_W-1:0] cal_word,
   output reg cal_start,
   output reg [3:0] cal_type,
   output reg cal_phase_fine,
   output reg five_wire_mode,
   output reg [`WORD_W-1:0] nr_ofs_sig,
   output reg [`WORD_W-1:0] nr_ofs_ref,
   output reg [`WORD_W-1:0] ratio_ofs,
   output reg [`WORD_W-1:0] gain,
   output reg [`TRIM_W-1:0] trim,
   output reg signed [9:0] trim_offset_pct,
   output reg [3:0] pga_gain,
   output reg [7:0] total_gain,
   output reg excitation_source,
   output reg [1:0] excitation_freq
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_COARSE = 2'h1;
   localparam ST_FINE = 2'h2;
   localparam ST_SINGLE = 2'h3;

   reg [`CFG_W-1:0] config_q;
   reg [`TRIM_W-1:0] trim_q;
   reg [`WORD_W-1:0] gain_q;
   reg [`WORD_W-1:0] ratio_q;
   reg [`WORD_W-1:0] nr_sig_q;
   reg [`WORD_W-1:0] nr_ref_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg mode_meta_q;
   reg mode_q;
   reg [`WORD_W-1:0] rdata_d;
   wire signed [9:0] trim_pct;
   wire gain_in_range;
   wire gain_rec;
   wire cal_exec;
   wire [3:0] cc;
   wire busy;
   wire launch;
   wire [1:0] pga_sel;
   wire [`ST_W-1:0] status;

   assign cal_exec = config_q[`CFG_CAL_EXEC_BIT];
   assign cc = config_q[`CFG_CC_HI:`CFG_CC_LO];
   assign busy = (state_q != ST_IDLE);
   // Start is judged on the old config word, so the write that sets
   // the enable bit does not itself launch a run
   assign launch = (state_q == ST_IDLE) && (state_d != ST_IDLE);
   assign pga_sel = config_q[`CFG_PGA_HI_BIT:`CFG_PGA_LO_BIT];

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [3:0] pga_decode;
      input [1:0] sel;
      begin
         pga_decode = 4'h1 << sel;
      end
   endfunction

   trim_decode u_trim
   (
      .trim(trim_q),
      .offset_pct(trim_pct)
   );

   gain_check u_gain
   (
      .gain(gain_q),
      .in_range(gain_in_range),
      .recommended(gain_rec)
   );

   // ----------------------------------------
   // Status word
   // ----------------------------------------
   // Range flags are advisory only; a gain outside them is still applied
   assign status[`ST_BUSY] = busy;
   assign status[`ST_GAIN_RANGE] = gain_in_range;
   assign status[`ST_GAIN_REC] = gain_rec;
   assign status[`ST_INTERFACE_MODE_PIN] = mode_q;

   // ----------------------------------------
   // Mode pin synchroniser
   // ----------------------------------------
   // Pin is asynchronous; only the second stage is read downstream
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_meta_q <= 1'b0;
         mode_q <= 1'b0;
      end
      else
      begin
         mode_meta_q <= interface_mode_pin;
         mode_q <= mode_meta_q;
      end
   end

   // ----------------------------------------
   // Calibration sequencer
   // ----------------------------------------
   // Any write with cal enable left set re-runs the selected calibration
   // Triggers while busy are dropped, so a run is never restarted midway
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (wr_stb && cal_exec)
            begin
               if (cc == `CC_RATIO)
                  state_d = ST_COARSE;
               else if (cc == `CC_NR_REF || cc == `CC_NR_SIG || cc == `CC_NR_BOTH || cc == `CC_GAIN)
                  state_d = ST_SINGLE;
            end
         end
         ST_COARSE:
            if (cal_done)
               state_d = ST_FINE;
         ST_FINE:
            if (cal_done)
               state_d = ST_IDLE;
         ST_SINGLE:
            if (cal_done)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Register file and state
   // ----------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         config_q <= `RST_CFG;
         trim_q <= `RST_TRIM;
         gain_q <= `RST_GAIN;
         ratio_q <= `RST_WORD;
         nr_sig_q <= `RST_WORD;
         nr_ref_q <= `RST_WORD;
         cal_start <= 1'b0;
         cal_type <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         cal_start <= launch;
         if (launch)
            cal_type <= cc;
         if (wr_stb)
         begin
            case (addr)
               `ADDR_CONFIG: config_q <= wdata[`CFG_HI:0];
               // Only the trim nibble takes the write; low bits mirror config
               `ADDR_TRIM: trim_q <= wdata[`TRIM_HI:`TRIM_LO];
               `ADDR_GAIN: gain_q <= wdata;
               `ADDR_RATIO_OFS: ratio_q <= wdata;
               `ADDR_NR_OFS_SIG: nr_sig_q <= wdata;
               `ADDR_NR_OFS_REF: nr_ref_q <= wdata;
               default: ;
            endcase
         end
         // Results from the engine override a same-cycle software write
         if (cal_done)
         begin
            case (state_q)
               ST_COARSE: trim_q <= cal_trim;
               ST_FINE: ratio_q <= cal_word;
               ST_SINGLE:
               begin
                  if (cal_type == `CC_NR_SIG || cal_type == `CC_NR_BOTH)
                     nr_sig_q <= cal_word;
                  if (cal_type == `CC_NR_REF || cal_type == `CC_NR_BOTH)
                     nr_ref_q <= cal_word;
                  if (cal_type == `CC_GAIN)
                     gain_q <= cal_word;
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always @*
   begin
      rdata_d = `UNMAPPED_RD;
      case (addr)
         `ADDR_CONFIG: rdata_d = {4'h0, config_q};
         `ADDR_TRIM: rdata_d = {trim_q, config_q};
         `ADDR_GAIN: rdata_d = gain_q;
         `ADDR_RATIO_OFS: rdata_d = ratio_q;
         `ADDR_NR_OFS_SIG: rdata_d = nr_sig_q;
         `ADDR_NR_OFS_REF: rdata_d = nr_ref_q;
         `ADDR_STATUS: rdata_d = {20'h00000, status};
         `ADDR_CAL_RESULT: rdata_d = {20'h00000, cal_type};
         default: rdata_d = `UNMAPPED_RD;
      endcase
   end

   // Zero outside the answer slot so a stale word never reads as an answer
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= `RST_WORD;
      else if (rd_stb)
         rdata <= rdata_d;
      else
         rdata <= `RST_WORD;
   end

   // ----------------------------------------
   // Registered outputs to the datapath
   // ----------------------------------------
   // Offsets (two's complement) and gain (unsigned) feed the post-processor as raw words;
   // the 2^-23 weighting is applied there, not here
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         five_wire_mode <= 1'b1;
         nr_ofs_sig <= `RST_WORD;
         nr_ofs_ref <= `RST_WORD;
         ratio_ofs <= `RST_WORD;
         gain <= `RST_GAIN;
         trim <= `RST_TRIM;
         trim_offset_pct <= 10'sh000;
         pga_gain <= 4'h1;
         total_gain <= `FE_GAIN;
         excitation_source <= 1'b0;
         excitation_freq <= 2'h0;
         cal_phase_fine <= 1'b0;
      end
      else
      begin
         five_wire_mode <= ~mode_q;
         nr_ofs_sig <= nr_sig_q;
         nr_ofs_ref <= nr_ref_q;
         ratio_ofs <= ratio_q;
         gain <= gain_q;
         trim <= trim_q;
         trim_offset_pct <= trim_pct;
         pga_gain <= pga_decode(pga_sel);
         total_gain <= (`FE_GAIN << pga_sel);
         excitation_source <= config_q[`CFG_EXC_BIT];
         excitation_freq <= config_q[`CFG_FREQ_HI_BIT:`CFG_FREQ_LO_BIT];
         cal_phase_fine <= (state_q == ST_FINE);
      end
   end

endmodule

// ===== hdl/cal_regs_consts.vh
/*
 Constants for the calibration register block: register indices, field
 positions, reset values and numeric format figures.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef CAL_REGS_CONSTS_VH
`define CAL_REGS_CONSTS_VH

// ----------------------------------------
// Register map (word addresses)
// ----------------------------------------
`define ADDR_W 4
`define ADDR_CONFIG 4'h0
`define ADDR_TRIM 4'h1
`define ADDR_GAIN 4'h2
`define ADDR_RATIO_OFS 4'h3
`define ADDR_NR_OFS_SIG 4'h4
`define ADDR_NR_OFS_REF 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_CAL_RESULT 4'h7

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define WORD_W 24
`define CFG_W 20
`define TRIM_W 4
`define RST_WORD 24'h000000
`define RST_CFG 20'h00000
`define RST_TRIM 4'h0
`define RST_GAIN 24'h800000
`define UNMAPPED_RD 24'h000000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRIM_SIGN_BIT 23
`define TRIM_MAG_HI 22
`define TRIM_MAG_LO 20
`define TRIM_HI 23
`define TRIM_LO 20
`define TRIM_NIB_SIGN 3
`define TRIM_NIB_MAG_HI 2
`define CFG_HI 19
`define CFG_EXC_BIT 19
`define CFG_FREQ_HI_BIT 18
`define CFG_FREQ_LO_BIT 17
`define CFG_PGA_HI_BIT 15
`define CFG_PGA_LO_BIT 14
`define CFG_CAL_EXEC_BIT 10
`define CFG_CC_HI 7
`define CFG_CC_LO 4
`define CFG_BIT0 0

// ----------------------------------------
// Calibration control codes (cal_ctrl_3..0)
// ----------------------------------------
`define CC_NR_REF 4'h8
`define CC_NR_SIG 4'h4
`define CC_RATIO 4'h2
`define CC_GAIN 4'h1
`define CC_NR_BOTH 4'hc

// ----------------------------------------
// Gain format: unsigned, one count is 2^-23, 1.0 at 0x800000
// ----------------------------------------
`define GAIN_FRAC_BITS 23
`define GAIN_MIN_OK 24'h400000
`define GAIN_REC_LO 24'h666666
`define GAIN_REC_HI 24'h99999a
`define FE_GAIN 8'h19
`define MAG_STEP_PCT 8'h19

// ----------------------------------------
// Status bits
// ----------------------------------------
`define ST_BUSY 0
`define ST_GAIN_RANGE 1
`define ST_GAIN_REC 2
`define ST_INTERFACE_MODE_PIN 3
`define ST_W 4

`endif

// ===== hdl/trim_decode.v
/*
 Decodes the coarse offset trim nibble into a signed offset in percent of
 nominal input.
 Assumes a purely combinational consumer on the same clock.
*/
`timescale 1ns/1ns
`include "cal_regs_consts.vh"

module trim_decode
(
   input wire [`TRIM_W-1:0] trim,
   output wire signed [9:0] offset_pct
);

   wire [2:0] mag;
   wire [9:0] mag_pct;

   assign mag = trim[`TRIM_NIB_MAG_HI:0];
   // Each code step is 25 percent; code 111 gives 175 percent
   assign mag_pct = {2'h0, mag * `MAG_STEP_PCT};
   // Zero magnitude applies nothing whatever the sign
   assign offset_pct = (mag == 3'h0) ? 10'sh000 :
                       (trim[`TRIM_NIB_SIGN] ? -$signed(mag_pct) : $signed(mag_pct));

endmodule

// ===== hdl/gain_check.v
/*
 Classifies the gain word against the working and recommended ranges.
 Assumes the word is unsigned with 23 fraction bits.
*/
`timescale 1ns/1ns
`include "cal_regs_consts.vh"

module gain_check
(
   input wire [`WORD_W-1:0] gain,
   output wire in_range,
   output wire recommended
);

   // Accepted working span is 0.5 to 2.0; above 1.2 codes may go missing
   assign in_range = (gain >= `GAIN_MIN_OK);
   // Calibrated words should lie within 0.8 to 1.2
   assign recommended = (gain >= `GAIN_REC_LO) && (gain <= `GAIN_REC_HI);

endmodule

// ===== test/cal_regs_props.sv
/* Port checker for cal_regs.
 Assumes one clock, bound onto every cal_regs instance. */
`timescale 1ns/1ns
`include "cal_regs_consts.vh"
module cal_regs_props
(
   input wire clk,
   input wire rst_n,
   input wire [`ADDR_W-1:0] addr,
   input wire [`WORD_W-1:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   input wire [`WORD_W-1:0] rdata,
   input wire interface_mode_pin,
   input wire cal_done,
   input wire [`TRIM_W-1:0] cal_trim,
   input wire [`WORD_W-1:0] cal_word,
   input wire cal_start,
   input wire [3:0] cal_type,
   input wire cal_phase_fine,
   input wire five_wire_mode,
   input wire [`WORD_W-1:0] ratio_ofs,
   input wire [`WORD_W-1:0] gain,
   input wire [`TRIM_W-1:0] trim,
   input wire signed [9:0] trim_offset_pct,
   input wire [3:0] pga_gain,
   input wire [7:0] total_gain
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------
   // Shadow of the configuration word
   // ------
   reg [`CFG_W-1:0] cfg_q;
   wire [9:0] mag_pct = trim[2:0] * 10'h19;
   wire [9:0] pct_exp = trim[`TRIM_SIGN_BIT-20] ? -mag_pct : mag_pct;
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
         cfg_q <= `RST_CFG;
      else if (wr_stb && addr == `ADDR_CONFIG)
         cfg_q <= wdata[`CFG_HI:0];
   property p_rst;
      $rose(rst_n) |-> gain == `RST_GAIN && trim == `RST_TRIM && ratio_ofs == `RST_WORD;
   endproperty
   a_rst: assert property (p_rst) else $error("reset store values wrong");
   property p_idle;
      !$past(rd_stb) |-> rdata == `UNMAPPED_RD;
   endproperty
   a_idle: assert property (p_idle) else $error("read data outside read slot");
   property p_unmap;
      rd_stb && addr > `ADDR_CAL_RESULT |=> rdata == `UNMAPPED_RD;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_mirror;
      rd_stb && addr == `ADDR_TRIM |=> rdata[`CFG_HI:0] == $past(cfg_q);
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror bits differ");
   property p_trim_wr;
      wr_stb && addr == `ADDR_TRIM ##2 rd_stb && addr == `ADDR_TRIM && !cal_done
         |=> rdata[`TRIM_HI:`TRIM_LO] == $past(wdata[`TRIM_HI:`TRIM_LO], 3);
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
   property p_mode;
      $stable(interface_mode_pin) [*4] |-> five_wire_mode == !interface_mode_pin;
   endproperty
   a_mode: assert property (p_mode) else $error("wire mode wrong");
   property p_pga;
      $stable(cfg_q) [*4] |-> pga_gain == 4'h1 << cfg_q[15:14] && total_gain == 8'h19 << cfg_q[15:14];
   endproperty
   a_pga: assert property (p_pga) else $error("gain selection wrong");
   property p_pct;
      $stable(trim) [*3] |-> trim_offset_pct == pct_exp;
   endproperty
   a_pct: assert property (p_pct) else $error("trim offset wrong");
   property p_start;
      cal_start |-> $past(wr_stb) && $past(cfg_q[`CFG_CAL_EXEC_BIT]) && cal_type == $past(cfg_q[7:4])
         ##1 !cal_start;
   endproperty
   a_start: assert property (p_start) else $error("bad calibration start");
   property p_gain_cal;
      cal_done && cal_type == `CC_GAIN |-> ##2 gain == $past(cal_word, 2);
   endproperty
   a_gain_cal: assert property (p_gain_cal) else $error("gain result lost");
   property p_coarse;
      cal_done && cal_type == `CC_RATIO && !cal_phase_fine |-> ##2 trim == $past(cal_trim, 2);
   endproperty
   a_coarse: assert property (p_coarse) else $error("coarse result lost");
   property p_fine;
      cal_done && cal_type == `CC_RATIO && cal_phase_fine |-> ##2 ratio_ofs == $past(cal_word, 2);
   endproperty
   a_fine: assert property (p_fine) else $error("fine result lost");
   c_start: cover property (cal_start);
   c_fine: cover property (cal_done && cal_phase_fine);
   c_mirror: cover property (rd_stb && addr == `ADDR_TRIM);
endmodule

bind cal_regs cal_regs_props u_cal_regs_props (.clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
   .interface_mode_pin, .cal_done, .cal_trim, .cal_word, .cal_start, .cal_type, .cal_phase_fine,
   .five_wire_mode, .ratio_ofs, .gain, .trim, .trim_offset_pct, .pga_gain, .total_gain);

// ===== test/cal_engine_model.sv
/* Calibration engine model answering each start after dly cycles.
 Assumes the bench sets dly of at least 2 and the result words. */
`timescale 1ns/1ns
`include "cal_regs_consts.vh"
module cal_engine_model
(
   input wire clk,
   input wire cal_start,
   input wire [3:0] cal_type,
   input wire [7:0] dly,
   input wire [3:0] res_trim,
   input wire [23:0] res_word,
   output reg cal_done,
   output reg act,
   output wire [3:0] cal_trim,
   output wire [23:0] cal_word
);
   reg [7:0] cnt_q = 8'h0;
   // Results only valid with the done pulse, noise otherwise
   assign cal_trim = cal_done ? res_trim : cnt_q[3:0];
   assign cal_word = cal_done ? res_word : {3{cnt_q}};
   initial cal_done = 1'b0;
   initial act = 1'b0;
   always @(posedge clk)
      cnt_q <= cnt_q + 8'h1;
   task phase;
   begin
      repeat (dly) @(posedge clk);
      cal_done <= 1'b1;
      @(posedge clk);
      cal_done <= 1'b0;
   end
   endtask
   always @(posedge clk)
      if (cal_start)
      begin
         act <= 1'b1;
         phase;
         if (cal_type == `CC_RATIO)
            phase;
         act <= 1'b0;
      end
endmodule

// ===== test/testbench.sv
/* Self-checking bench for cal_regs.
 Assumes checker and engine model compiled first. */
`timescale 1ns/1ns
`include "cal_regs_consts.vh"
module testbench;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [23:0] wdata = 24'h0;
   reg wr_stb = 1'b0;
   reg rd_stb = 1'b0;
   reg interface_mode_pin = 1'b0;
   reg [7:0] dly = 8'h2;
   reg [3:0] res_trim = 4'h0;
   reg [23:0] res_word = 24'h0;
   reg [31:0] lfsr = 32'h9fc07bba;
   reg [23:0] exp_q[$];
   reg [23:0] cfg;
   reg [9:0] pct;
   reg pend = 1'b0;
   integer miscompares = 0;
   integer num_checks = 0;
   integer i;
   wire [23:0] rdata, cal_word, gain, ratio_ofs, nr_ofs_sig, nr_ofs_ref;
   wire excitation_source;
   wire [1:0] excitation_freq;
   wire cal_done, act, cal_start, cal_phase_fine, five_wire_mode;
   wire [3:0] cal_trim, cal_type, trim, pga_gain;
   wire signed [9:0] trim_offset_pct;
   wire [7:0] total_gain;
   cal_regs u_cal_regs (.clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .interface_mode_pin,
      .cal_done, .cal_trim, .cal_word, .cal_start, .cal_type, .cal_phase_fine, .five_wire_mode,
      .nr_ofs_sig, .nr_ofs_ref, .ratio_ofs, .gain, .trim, .trim_offset_pct, .pga_gain,
      .total_gain, .excitation_source, .excitation_freq);
   cal_engine_model u_cal_engine_model (.clk, .cal_start, .cal_type, .dly, .res_trim, .res_word,
      .cal_done, .act, .cal_trim, .cal_word);
   always #4 clk = ~clk;
   function [31:0] rnd(input [31:0] s);
      rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [23:0] seen, input [23:0] exp);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task wr(input [3:0] a, input [23:0] d);
   begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   end
   endtask
   task rd(input [3:0] a, input [23:0] e);
   begin
      exp_q.push_back(e);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
   end
   endtask
   task cal_wait;
      integer n;
   begin
      repeat (3) @(posedge clk);
      n = 0;
      while (act === 1'b1 && n < 200)
      begin
         @(posedge clk);
         n = n + 1;
      end
      chk(n < 200, 24'h1);
   end
   endtask
   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   // Read data stands one cycle; sampled mid-cycle
   always @(negedge clk)
   begin
      if (pend)
         chk(rdata, exp_q.pop_front());
      pend = rd_stb;
   end
   initial
   begin
      #200000;
      miscompares = miscompares + 1;
      wrap_up;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i = i + 1)
         rd(i[3:0], i == 2 ? `RST_GAIN : 24'h0);
      rd(4'hf, `UNMAPPED_RD);
      rd(`ADDR_STATUS, 24'h6);
      $display("reset test done");
      for (i = 2; i < 6; i = i + 1)
      begin
         lfsr = rnd(lfsr);
         wr(i[3:0], lfsr[23:0]);
         rd(i[3:0], lfsr[23:0]);
         case (i)
            2: chk(gain, lfsr[23:0]);
            3: chk(ratio_ofs, lfsr[23:0]);
            4: chk(nr_ofs_sig, lfsr[23:0]);
            default: chk(nr_ofs_ref, lfsr[23:0]);
         endcase
      end
      wr(`ADDR_GAIN, 24'h300000);
      rd(`ADDR_STATUS, 24'h0);
      wr(`ADDR_GAIN, 24'hc00000);
      rd(`ADDR_STATUS, 24'h2);
      $display("readback test done");
      for (i = 0; i < 4; i = i + 1)
      begin
         lfsr = rnd(lfsr);
         cfg = {4'h0, lfsr[19:16], i[1:0], lfsr[13:11], 1'b0, lfsr[9:0]};
         wr(`ADDR_CONFIG, cfg);
         wr(`ADDR_TRIM, 24'hffffff);
         rd(`ADDR_TRIM, {4'hf, cfg[19:0]});
         chk({20'h0, pga_gain}, 24'h1 << i);
         chk({16'h0, total_gain}, 24'h19 << i);
         chk({21'h0, excitation_source, excitation_freq}, {21'h0, cfg[19:17]});
      end
      $display("mirror test done");
      for (i = 0; i < 16; i = i + 1)
      begin
         wr(`ADDR_TRIM, {i[3:0], 20'h0});
         repeat (3) @(posedge clk);
         pct = i[2:0] * 10'h19;
         if (i[3])
            pct = -pct;
         chk({14'h0, trim_offset_pct}, {14'h0, pct});
         chk({20'h0, trim}, {20'h0, i[3:0]});
      end
      $display("trim test done");
      for (i = 0; i < 2; i = i + 1)
      begin
         interface_mode_pin <= !i[0];
         repeat (5) @(posedge clk);
         chk({23'h0, five_wire_mode}, {23'h0, i[0]});
      end
      $display("mode test done");
      for (i = 0; i < 5; i = i + 1)
      begin
         lfsr = rnd(lfsr);
         res_word <= lfsr[23:0];
         res_trim <= lfsr[27:24];
         dly <= i[0] ? 8'h28 : 8'h2;
         cfg = 24'h000400 | (((24'h2c148 >> (4 * i)) & 24'hf) << 4);
         wr(`ADDR_CONFIG, cfg);
         // Second write starts it; the closing write re-runs it
         wr(`ADDR_CONFIG, cfg);
         cal_wait;
         wr(`ADDR_CONFIG, 24'h0);
         cal_wait;
         case (cfg[7:4])
            `CC_NR_REF: rd(`ADDR_NR_OFS_REF, res_word);
            `CC_NR_SIG: rd(`ADDR_NR_OFS_SIG, res_word);
            `CC_GAIN: rd(`ADDR_GAIN, res_word);
            `CC_NR_BOTH:
            begin
               rd(`ADDR_NR_OFS_SIG, res_word);
               rd(`ADDR_NR_OFS_REF, res_word);
            end
            default:
            begin
               rd(`ADDR_RATIO_OFS, res_word);
               rd(`ADDR_TRIM, {res_trim, 20'h0});
            end
         endcase
         rd(`ADDR_CAL_RESULT, {20'h0, cfg[7:4]});
      end
      $display("calibration test done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`ADDR_GAIN, `RST_GAIN);
      rd(`ADDR_TRIM, 24'h0);
      repeat (3) @(posedge clk);
      $display("second reset test done");
      wrap_up;
   end
endmodule
